/* inc/fwp_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// flash write-protection block. Assumes byte offsets on the plain register port.
`ifndef FWP_REGS_SVH
`define FWP_REGS_SVH

// Register offsets (byte addresses)
`define FWP_OFS_STATUS    8'h00
`define FWP_OFS_CONFIG    8'h04
`define FWP_OFS_MODE      8'h08
`define FWP_OFS_ADDR      8'h0c
`define FWP_OFS_DATA      8'h10
`define FWP_OFS_PASS_LO   8'h14
`define FWP_OFS_PASS_HI   8'h18
`define FWP_OFS_CMD       8'h1c
`define FWP_OFS_VIEW      8'h20

// Field positions
`define FWP_BIT_WIP       0
`define FWP_BIT_WEL       1
`define FWP_BIT_GUARD_LO  2
`define FWP_BIT_PERR      6
`define FWP_BIT_STATUS_WRITE_DISABLE_BIT      7
`define FWP_BIT_FREEZE    0
`define FWP_BIT_TBSEL     5
`define FWP_BIT_CFG_SHIFT 8
`define FWP_BIT_MODE_LO   1

// Reset and factory values
`define FWP_MODE_NONE     2'b11
`define FWP_MODE_PERSIST  2'b10
`define FWP_MODE_PASSWORD 2'b01
`define FWP_MODE_ILLEGAL  2'b00
`define FWP_PASS_FACTORY  64'hffff_ffff_ffff_ffff
`define FWP_LOCK_FACTORY  32'hffff_ffff
`define FWP_LOCK_BASE     10'h010

// Timing: core clock, page-program time and unlock pacing
`define FWP_CLK_MHZ       200
`define FWP_PROG_NS       1000
`define FWP_UNLOCK_US     100
`define FWP_PROG_CYC      ((`FWP_PROG_NS * `FWP_CLK_MHZ) / 1000)
`define FWP_UNLOCK_CYC    (`FWP_UNLOCK_US * `FWP_CLK_MHZ)

`endif

/* inc/fwp_pkg.sv */
// Types shared by the flash write-protection block.
// Assumes fwp_regs.svh supplies all numeric constants.
package fwp_pkg;

    // Commands as queued through the command register
    typedef enum logic [3:0] {
        FWP_WRITE_ENABLE_CMD = 4'h0, FWP_WRITE_DISABLE  = 4'h1,
        FWP_WRITE_REGS       = 4'h2, FWP_PAGE_PROGRAM   = 4'h3,
        FWP_SECTOR_ERASE     = 4'h4, FWP_OTP_PROGRAM    = 4'h5,
        FWP_MODE_PROGRAM     = 4'h6, FWP_PSL_PROGRAM    = 4'h7,
        FWP_PSL_ERASE        = 4'h8, FWP_PASS_PROGRAM   = 4'h9,
        FWP_PASS_UNLOCK      = 4'ha, FWP_GATE_CLEAR     = 4'hb,
        FWP_DSL_WRITE        = 4'hc, FWP_TRAIN_PROGRAM  = 4'hd,
        FWP_CLEAR_STATUS     = 4'he, FWP_SOFT_RESET     = 4'hf
    } fwp_cmd_t;

    typedef enum logic [1:0] {
        FWP_ST_IDLE = 2'b01,
        FWP_ST_BUSY = 2'b10
    } fwp_state_t;

    // Array request handed to the program/erase engine
    typedef struct packed {
        logic        go;
        logic        erase;
        logic [15:0] sector;
    } fwp_arr_req_t;

endpackage

/* hw/fwp_core.sv */
// Write-protection logic of a serial NOR flash: write latch, OTP lock bytes,
// block guard span, freeze, write-protect pin and advanced sector guard.
// Assumes a command decoder queues commands through the register port and
// that the SPI pins arrive asynchronously; the core clock samples them.
//
// Functional notes
// - Lock byte bit b of byte k guards OTP region 8k+b.
// - Bit zero of lock byte 0x10 locks lock and reserved bytes of region 0.
// - Write-enable sets latch; modifying commands refused while latch clear.
// - Latch cleared at reset, soft reset, write disable, modify completion.
// - Three guard bits select none, 1/64 doubling to 1/2, or whole array.
// - Bottom-select 0 guards top of array, 1 guards bottom.
// - Sector protected if guard span OR sector guard protects it.
// - Freeze keeps guard bits and OTP unchangeable until power cycle.
// - Pin low with status-write-disable set blocks status/config writes.
// - Sector refused when persistent or dynamic lock is zero.
// - Persistent lock program/erase refused while lock gate is zero.
// - Persistent mode: gate set at reset, clearable, never set by command.
// - Password mode: gate cleared at reset and clearable by command.
// - Password mode: gate set only on 64-bit password match.
// - Mode bits 2:1: 11 none, 10 persistent, 01 password.
// - Programming mode bits to 00 fails as a program error.
// - Factory device: persistent behaviour, all sectors unprotected.
// - After mode chosen, OTP config, mode, password, training writes fail.
// - Mode register program keeps busy for one page-program time.
// - Persistent locks cleared singly, set back to one all together.
// - Dynamic lock written freely to protect or unprotect a sector.
// - Wrong password: error, busy held unlock time, gate stays zero.
`timescale 1ns/10ps
`include "fwp_regs.svh"

module fwp_core #(
    parameter int NUM_SECTORS = 64,
    parameter int PROG_CYC    = `FWP_PROG_CYC,
    parameter int UNLOCK_CYC  = `FWP_UNLOCK_CYC
) (
    input  wire logic                 CORE_CLK_I,
    input  wire logic                 SRST_I,
    input  wire logic                 WP_N_I,
    input  wire logic                 HW_RST_N_I,
    input  wire logic                 CS_N_I,
    input  wire logic                 SCK_I,
    input  wire logic [7:0]           ADDR_I,
    input  wire logic [31:0]          WDATA_I,
    input  wire logic                 WR_I,
    input  wire logic                 RD_I,
    output logic      [31:0]          RDATA_O,
    output logic                      WIP_O,
    output fwp_pkg::fwp_arr_req_t     ARRAY_REQ_O
);
    import fwp_pkg::*;

    localparam int SECT_W = $clog2(NUM_SECTORS);
    localparam int CNT_W  = $clog2(UNLOCK_CYC + PROG_CYC + 2);

    // Commands that need the write latch, shared by decision and checks
    function automatic logic needs_latch(input fwp_cmd_t op);
        needs_latch = !(op inside {FWP_WRITE_ENABLE_CMD, FWP_WRITE_DISABLE,
                                   FWP_PASS_UNLOCK, FWP_CLEAR_STATUS, FWP_SOFT_RESET});
    endfunction

    // Commands that run the busy timer and close the write latch at the end
    function automatic logic latch_op_q_next(input fwp_cmd_t op);
        latch_op_q_next = needs_latch(op) && op != FWP_GATE_CLEAR
                          && op != FWP_DSL_WRITE;
    endfunction

    // Guard span hit: span is NUM_SECTORS >> (7 - code), code 7 is all
    function automatic logic span_hit(input logic [2:0] code, input logic bottom,
                                      input logic [SECT_W-1:0] s);
        logic [SECT_W:0] span;
        span = (SECT_W+1)'(NUM_SECTORS >> (3'd7 - code));
        if (code == 3'd0)
            span_hit = 1'b0;
        else if (code == 3'd7)
            span_hit = 1'b1;
        else if (bottom)
            span_hit = {1'b0, s} < span;
        else
            span_hit = {1'b0, s} >= ((SECT_W+1)'(NUM_SECTORS) - span);
    endfunction

    fwp_state_t           state_q, state_d;
    logic [3:0]           sync1_q, sync2_q, sync3_q;
    logic [7:0]           sck_cnt_q;
    logic                 pend_q;
    fwp_cmd_t             op_q;
    logic [31:0]          addr_q, data_q, pass_lo_q, pass_hi_q;
    logic                 wel_q, perr_q, status_write_disable_bit_q, freeze_q, tbsel_q, gate_q;
    logic [2:0]           guard_q;
    logic [1:0]           mode_q;
    logic [63:0]          pass_q;
    logic [7:0]           train_q;
    logic [31:0]          lock_q;
    logic [NUM_SECTORS-1:0] psl_q, dsl_q;
    logic [CNT_W-1:0]     cnt_q, cnt_d;
    logic                 latch_op_q;
    logic                 hw_rst, frame_end, exec, accept, fail, done;
    logic                 blk_prot, sect_prot, otp_locked, mode_set, wp_guard, pass_bad;
    logic [SECT_W-1:0]    sect;
    logic [9:0]           otp_ofs;
    logic [31:0]          rd_mux;

    // Two flip-flops before use, third stage only for edge finding
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            sync1_q <= 4'h6;
            sync2_q <= 4'h6;
            sync3_q <= 4'h6;
        end else begin
            sync1_q <= {SCK_I, CS_N_I, HW_RST_N_I, WP_N_I};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    assign hw_rst    = ~sync2_q[1];
    assign frame_end = sync2_q[2] & ~sync3_q[2];

    // Serial clock edges in the frame; only whole bytes execute a command
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || frame_end)
            sck_cnt_q <= 8'h00;
        else if (~sync2_q[2] && sync2_q[3] && ~sync3_q[3])
            sck_cnt_q <= sck_cnt_q + 8'h01;
    end

    // Decision inputs from the latched address and password, stored state and the pin
    assign sect      = addr_q[SECT_W-1:0];
    assign otp_ofs   = addr_q[9:0];
    assign mode_set  = mode_q != `FWP_MODE_NONE;
    assign wp_guard  = ~sync2_q[0] & status_write_disable_bit_q;
    assign blk_prot  = span_hit(guard_q, tbsel_q, sect);
    assign sect_prot = blk_prot | ~psl_q[sect] | ~dsl_q[sect];
    assign pass_bad  = (mode_q != `FWP_MODE_PASSWORD) || (pass_q != {pass_hi_q, pass_lo_q});
    // Region 0 lower half is not guarded by its own lock bit
    assign otp_locked = freeze_q | ((otp_ofs[9:5] == 5'd0) ?
                        (otp_ofs[4] & ~lock_q[0]) : ~lock_q[otp_ofs[9:5]]);

    assign exec   = pend_q && frame_end && (state_q == FWP_ST_IDLE)
                    && (sck_cnt_q[2:0] == 3'd0) && (sck_cnt_q != 8'h00);
    assign accept = exec && (!needs_latch(op_q) || wel_q);

    // Failure decision per command
    always_comb begin
        fail = 1'b0;
        unique case (op_q)
            FWP_WRITE_REGS:   fail = wp_guard || (data_q[`FWP_BIT_CFG_SHIFT + `FWP_BIT_TBSEL]
                                     && !tbsel_q && (mode_set || freeze_q));
            FWP_PAGE_PROGRAM,
            FWP_SECTOR_ERASE: fail = sect_prot;
            FWP_OTP_PROGRAM:  fail = otp_locked;
            FWP_MODE_PROGRAM: fail = mode_set || (data_q[2:1] == `FWP_MODE_ILLEGAL);
            FWP_PSL_PROGRAM,
            FWP_PSL_ERASE:    fail = ~gate_q;
            FWP_PASS_PROGRAM,
            FWP_TRAIN_PROGRAM: fail = mode_set;
            FWP_PASS_UNLOCK:  fail = pass_bad;
            default:          fail = 1'b0;
        endcase
    end

    // Busy length: page time for nonvolatile writes, pacing on a bad password
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done    = 1'b0;
        unique case (state_q)
            FWP_ST_IDLE: begin
                if (accept && op_q == FWP_PASS_UNLOCK) begin
                    state_d = FWP_ST_BUSY;
                    cnt_d   = fail ? CNT_W'(UNLOCK_CYC - 1) : '0;
                end else if (accept && latch_op_q_next(op_q)) begin
                    state_d = FWP_ST_BUSY;
                    cnt_d   = fail ? '0 : CNT_W'(PROG_CYC - 1);
                end
            end
            FWP_ST_BUSY: begin
                if (cnt_q == '0) begin
                    state_d = FWP_ST_IDLE;
                    done    = 1'b1;
                end else begin
                    cnt_d = cnt_q - CNT_W'(1);
                end
            end
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || hw_rst) begin
            state_q    <= FWP_ST_IDLE;
            cnt_q      <= '0;
            WIP_O      <= 1'b0;
            latch_op_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            WIP_O   <= state_d == FWP_ST_BUSY;
            if (accept)
                latch_op_q <= needs_latch(op_q);
        end
    end

    // Write latch
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || hw_rst)
            wel_q <= 1'b0;
        else if (accept && op_q == FWP_WRITE_ENABLE_CMD)
            wel_q <= 1'b1;
        else if (accept && (op_q inside {FWP_WRITE_DISABLE, FWP_SOFT_RESET,
                                         FWP_GATE_CLEAR, FWP_DSL_WRITE}))
            wel_q <= 1'b0;
        else if (done && latch_op_q)
            wel_q <= 1'b0;
    end

    // Program error flag; set on any failed accepted command
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || hw_rst)
            perr_q <= 1'b0;
        else if (accept && fail)
            perr_q <= 1'b1;
        else if (accept && op_q == FWP_CLEAR_STATUS)
            perr_q <= 1'b0;
    end

    // Status and configuration one; freeze lasts until power-on reset only
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            guard_q  <= 3'd0;
            status_write_disable_bit_q   <= 1'b0;
            tbsel_q  <= 1'b0;
            freeze_q <= 1'b0;
        end else if (accept && !fail && op_q == FWP_WRITE_REGS) begin
            if (!freeze_q) begin
                guard_q <= data_q[`FWP_BIT_GUARD_LO +: 3];
                tbsel_q <= tbsel_q | data_q[`FWP_BIT_CFG_SHIFT + `FWP_BIT_TBSEL];
            end
            status_write_disable_bit_q   <= data_q[`FWP_BIT_STATUS_WRITE_DISABLE_BIT];
            freeze_q <= freeze_q | data_q[`FWP_BIT_CFG_SHIFT + `FWP_BIT_FREEZE];
        end
    end

    // One-time mode bits, password, training pattern and OTP lock bytes
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            mode_q  <= `FWP_MODE_NONE;
            pass_q  <= `FWP_PASS_FACTORY;
            train_q <= 8'h00;
            lock_q  <= `FWP_LOCK_FACTORY;
        end else if (accept && !fail) begin
            if (op_q == FWP_MODE_PROGRAM)
                mode_q <= data_q[2:1];
            if (op_q == FWP_PASS_PROGRAM)
                pass_q <= pass_q & {pass_hi_q, pass_lo_q};
            if (op_q == FWP_TRAIN_PROGRAM)
                train_q <= data_q[7:0];
            if (op_q == FWP_OTP_PROGRAM && otp_ofs[9:2] == `FWP_LOCK_BASE >> 2)
                lock_q[otp_ofs[1:0]*8 +: 8] <= lock_q[otp_ofs[1:0]*8 +: 8] & data_q[7:0];
        end
    end

    // Lock gate: reset value follows the chosen mode
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I)
            gate_q <= 1'b1;
        else if (hw_rst)
            gate_q <= mode_q != `FWP_MODE_PASSWORD;
        else if (accept && op_q == FWP_GATE_CLEAR)
            gate_q <= 1'b0;
        else if (accept && op_q == FWP_PASS_UNLOCK && !fail)
            gate_q <= 1'b1;
    end

    // Persistent sector locks: cleared one at a time, set back all at once
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I)
            psl_q <= '1;
        else if (accept && !fail && op_q == FWP_PSL_PROGRAM)
            psl_q[sect] <= 1'b0;
        else if (accept && !fail && op_q == FWP_PSL_ERASE)
            psl_q <= '1;
    end

    // Dynamic sector locks, volatile
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I || hw_rst)
            dsl_q <= '1;
        else if (accept && op_q == FWP_DSL_WRITE)
            dsl_q[sect] <= data_q[0];
    end

    // Array request only for unprotected program or erase
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ARRAY_REQ_O <= '0;
        end else begin
            ARRAY_REQ_O.go     <= accept && !fail &&
                                  (op_q inside {FWP_PAGE_PROGRAM, FWP_SECTOR_ERASE});
            ARRAY_REQ_O.erase  <= op_q == FWP_SECTOR_ERASE;
            ARRAY_REQ_O.sector <= 16'(sect);
        end
    end

    // Register writes and the command queue
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            addr_q    <= 32'h0;
            data_q    <= 32'h0;
            pass_lo_q <= 32'h0;
            pass_hi_q <= 32'h0;
            pend_q    <= 1'b0;
            op_q      <= FWP_WRITE_DISABLE;
        end else begin
            if (WR_I && ADDR_I == `FWP_OFS_ADDR)
                addr_q <= WDATA_I;
            if (WR_I && ADDR_I == `FWP_OFS_DATA)
                data_q <= WDATA_I;
            if (WR_I && ADDR_I == `FWP_OFS_PASS_LO)
                pass_lo_q <= WDATA_I;
            if (WR_I && ADDR_I == `FWP_OFS_PASS_HI)
                pass_hi_q <= WDATA_I;
            if (WR_I && ADDR_I == `FWP_OFS_CMD) begin
                pend_q <= 1'b1;
                op_q   <= fwp_cmd_t'(WDATA_I[3:0]);
            end else if (frame_end) begin
                pend_q <= 1'b0;
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        unique case (ADDR_I)
            `FWP_OFS_STATUS:  rd_mux = {24'h0, status_write_disable_bit_q, perr_q, 1'b0, guard_q, wel_q, WIP_O};
            `FWP_OFS_CONFIG:  rd_mux = {26'h0, tbsel_q, 4'h0, freeze_q};
            `FWP_OFS_MODE:    rd_mux = {16'h0, train_q, 5'h0, mode_q, gate_q};
            `FWP_OFS_ADDR:    rd_mux = addr_q;
            `FWP_OFS_DATA:    rd_mux = data_q;
            `FWP_OFS_PASS_LO: rd_mux = pass_lo_q;
            `FWP_OFS_PASS_HI: rd_mux = pass_hi_q;
            `FWP_OFS_CMD:     rd_mux = {27'h0, pend_q, op_q};
            `FWP_OFS_VIEW:    rd_mux = {28'h0, blk_prot, psl_q[sect], dsl_q[sect], sect_prot};
            default:          rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I)
            RDATA_O <= 32'h0;
        else if (RD_I)
            RDATA_O <= rd_mux;
        else
            RDATA_O <= 32'h0;
    end

    // Checks
    sequence s_bad_unlock;
        accept && op_q == FWP_PASS_UNLOCK && fail;
    endsequence
    sequence s_held_busy;
        (WIP_O && !gate_q) [*8];
    endsequence

    chk_latch_set: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I || hw_rst)
        accept && op_q == FWP_WRITE_ENABLE_CMD |=> wel_q)
        else $error("write latch not set");
    chk_latch_refuse: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        exec && needs_latch(op_q) && !wel_q |=> !ARRAY_REQ_O.go && $stable(perr_q))
        else $error("command taken without write latch");
    chk_latch_clear: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I || hw_rst)
        done && latch_op_q |=> !wel_q)
        else $error("write latch not cleared");
    chk_go_unprot: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        accept && op_q == FWP_PAGE_PROGRAM && sect_prot |=> !ARRAY_REQ_O.go && perr_q)
        else $error("protected sector written");
    chk_gate_persist: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I || hw_rst)
        mode_q != `FWP_MODE_PASSWORD && !gate_q |=> !gate_q)
        else $error("gate set in persistent mode");
    chk_mode_legal: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        accept && op_q == FWP_MODE_PROGRAM && data_q[2:1] == `FWP_MODE_ILLEGAL
        |=> perr_q && mode_q != `FWP_MODE_ILLEGAL)
        else $error("illegal mode accepted");
    chk_freeze_hold: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        freeze_q |=> $stable(guard_q) && $stable(tbsel_q) && $stable(lock_q))
        else $error("frozen bits changed");
    chk_pin_guard: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        accept && op_q == FWP_WRITE_REGS && wp_guard
        |=> $stable(guard_q) && $stable(status_write_disable_bit_q) && $stable(freeze_q))
        else $error("status written under pin guard");
    chk_psl_gate: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I)
        accept && op_q inside {FWP_PSL_PROGRAM, FWP_PSL_ERASE} && !gate_q |=> $stable(psl_q))
        else $error("persistent lock changed with gate closed");
    chk_unlock_pace: assert property (@(posedge CORE_CLK_I) disable iff (SRST_I || hw_rst)
        s_bad_unlock |=> s_held_busy)
        else $error("bad password not paced");

endmodule

/* tb/fwp_host_model.sv */
// SPI host model: sends whole command frames of serial clock pulses.
// Assumes the core clock paces it; 32 core cycles make one 160 ns period.
`timescale 1ns/10ps

module fwp_host_model (
    input  wire logic clk_i,
    output logic      cs_n_o,
    output logic      sck_o
);
    // Idle: deselected, serial clock parked low between frames
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
    end

    // One frame per command; the bench queues the command before framing it
    task automatic frame(input int nbits);
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        repeat (nbits) begin
            repeat (16) @(posedge clk_i);
            sck_o <= 1'b1;
            repeat (16) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        repeat (16) @(posedge clk_i);
        cs_n_o <= 1'b1;
    endtask
endmodule

/* tb/flash_write_protect_logic_bench.sv */
// Self-checking bench of the write-protection core: register reads and
// writes plus SPI frames. Assumes short program and unlock counts.
`timescale 1ns/10ps
`include "fwp_regs.svh"

module flash_write_protect_logic_bench;
    import fwp_pkg::*;
    logic         clk, srst, wp_n, hw_n, wr, rd, operation_in_progress, cs_n, sck;
    logic [7:0]   addr;
    logic [31:0]  wdata, rdata;
    fwp_arr_req_t req, last_req;
    int           error_cnt, n_compared, n_go;

    fwp_core #(.NUM_SECTORS(64), .PROG_CYC(4), .UNLOCK_CYC(16)) dut (
        .CORE_CLK_I(clk), .SRST_I(srst), .WP_N_I(wp_n), .HW_RST_N_I(hw_n),
        .CS_N_I(cs_n), .SCK_I(sck), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .WIP_O(operation_in_progress), .ARRAY_REQ_O(req));
    fwp_host_model host (.clk_i(clk), .cs_n_o(cs_n), .sck_o(sck));

    // 200 MHz core clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Array requests counted, since a go pulse lasts one cycle
    always @(posedge clk) begin
        if (req.go === 1'b1) begin
            n_go     <= n_go + 1;
            last_req <= req;
        end
    end

    task automatic chk(input logic [31:0] got, exp, input string what);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input string what,
                          input logic [31:0] mask = 32'hffff_ffff);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata & mask, exp, what);
    endtask

    // Queue a command, frame it, then poll busy under a bound
    task automatic run_cmd(input fwp_cmd_t op, input logic [31:0] a = 0, d = 0);
        int n;
        wr_reg(`FWP_OFS_ADDR, a);
        wr_reg(`FWP_OFS_DATA, d);
        wr_reg(`FWP_OFS_CMD, {28'h0, op});
        host.frame(8);
        repeat (6) @(posedge clk);
        n = 0;
        while (operation_in_progress === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        if (n >= 200) begin
            error_cnt++;
            $display("mismatch at %0t: busy never ends", $time);
            summarize();
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic hw_pulse();
        @(posedge clk);
        hw_n <= 1'b0;
        repeat (4) @(posedge clk);
        hw_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        {srst, wp_n, hw_n} = 3'b111;
        {wr, rd, addr, wdata} = '0;
        {error_cnt, n_compared} = '0;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        repeat (4) @(posedge clk);
        rd_reg(`FWP_OFS_STATUS, 32'h0, "status at reset");
        rd_reg(`FWP_OFS_MODE, 32'h7, "mode at reset");
        rd_reg(`FWP_OFS_VIEW, 32'h6, "factory sector");
        $display("test reset done");
        run_cmd(FWP_PAGE_PROGRAM);
        chk(n_go, 0, "program without latch");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        rd_reg(`FWP_OFS_STATUS, 32'h2, "latch set");
        run_cmd(FWP_WRITE_DISABLE);
        rd_reg(`FWP_OFS_STATUS, 32'h0, "latch dropped");
        $display("test latch done");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_WRITE_REGS, 0, 32'h4);
        rd_reg(`FWP_OFS_STATUS, 32'h4, "guard set, latch cleared");
        wr_reg(`FWP_OFS_ADDR, 32'd63);
        rd_reg(`FWP_OFS_VIEW, 32'hf, "top sector guarded");
        wr_reg(`FWP_OFS_ADDR, 32'd62);
        rd_reg(`FWP_OFS_VIEW, 32'h6, "next sector free");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_PAGE_PROGRAM, 32'd63);
        rd_reg(`FWP_OFS_STATUS, 32'h44, "protected program");
        chk(n_go, 0, "no array request");
        run_cmd(FWP_CLEAR_STATUS);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_PAGE_PROGRAM, 32'd0);
        chk(n_go, 1, "free sector programmed");
        chk({14'h0, last_req}, 32'h2_0000, "program request");
        $display("test guard span done");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_DSL_WRITE, 32'd5, 32'h0);
        rd_reg(`FWP_OFS_VIEW, 32'h5, "dynamic lock cleared");
        hw_pulse();
        rd_reg(`FWP_OFS_VIEW, 32'h6, "dynamic lock after pin reset");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_GATE_CLEAR);
        rd_reg(`FWP_OFS_MODE, 32'h6, "gate cleared");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_PSL_PROGRAM, 32'd5);
        rd_reg(`FWP_OFS_STATUS, 32'h44, "persistent lock refused");
        run_cmd(FWP_CLEAR_STATUS);
        hw_pulse();
        rd_reg(`FWP_OFS_MODE, 32'h7, "gate set by pin reset");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_MODE_PROGRAM, 0, 32'h0);
        rd_reg(`FWP_OFS_STATUS, 32'h44, "illegal mode");
        rd_reg(`FWP_OFS_MODE, 32'h7, "mode unchanged");
        $display("test sector guard done");
        run_cmd(FWP_CLEAR_STATUS);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_WRITE_REGS, 0, 32'h84);
        rd_reg(`FWP_OFS_STATUS, 32'h84, "write disable set");
        wp_n <= 1'b0;
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_WRITE_REGS, 0, 32'h0);
        rd_reg(`FWP_OFS_STATUS, 32'h84, "pin blocks write", 32'h9c);
        $display("test write pin done");
        wp_n <= 1'b1;
        run_cmd(FWP_CLEAR_STATUS);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_OTP_PROGRAM, 32'h11, 32'hfd);
        rd_reg(`FWP_OFS_STATUS, 32'h84, "lock byte written");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_OTP_PROGRAM, 32'h120);
        rd_reg(`FWP_OFS_STATUS, 32'hc4, "locked region refused");
        run_cmd(FWP_CLEAR_STATUS);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_OTP_PROGRAM, 32'h10, 32'hfe);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_OTP_PROGRAM, 32'h13);
        rd_reg(`FWP_OFS_STATUS, 32'hc4, "lock bytes locked");
        $display("test otp done");
        run_cmd(FWP_CLEAR_STATUS);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_PSL_PROGRAM, 32'd7);
        rd_reg(`FWP_OFS_VIEW, 32'h3, "persistent lock set");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_PSL_ERASE, 32'd7);
        rd_reg(`FWP_OFS_VIEW, 32'h6, "persistent locks erased");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_SECTOR_ERASE, 32'd1);
        chk({14'h0, last_req}, 32'h3_0001, "erase request");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_SOFT_RESET);
        rd_reg(`FWP_OFS_STATUS, 32'h84, "latch dropped by soft reset");
        $display("test persistent lock done");
        wr_reg(`FWP_OFS_PASS_LO, 32'h1234_5678);
        wr_reg(`FWP_OFS_PASS_HI, 32'h0);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_PASS_PROGRAM);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_MODE_PROGRAM, 0, 32'h2);
        rd_reg(`FWP_OFS_MODE, 32'h3, "password mode");
        hw_pulse();
        rd_reg(`FWP_OFS_MODE, 32'h2, "gate closed by pin reset");
        wr_reg(`FWP_OFS_PASS_LO, 32'h0);
        run_cmd(FWP_PASS_UNLOCK);
        rd_reg(`FWP_OFS_STATUS, 32'hc4, "bad password");
        rd_reg(`FWP_OFS_MODE, 32'h2, "gate stays closed");
        run_cmd(FWP_CLEAR_STATUS);
        wr_reg(`FWP_OFS_PASS_LO, 32'h1234_5678);
        run_cmd(FWP_PASS_UNLOCK);
        rd_reg(`FWP_OFS_MODE, 32'h3, "gate opened by password");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_TRAIN_PROGRAM, 0, 32'h5a);
        rd_reg(`FWP_OFS_STATUS, 32'hc4, "training locked");
        rd_reg(`FWP_OFS_MODE, 32'h3, "training unchanged");
        run_cmd(FWP_CLEAR_STATUS);
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_GATE_CLEAR);
        rd_reg(`FWP_OFS_MODE, 32'h2, "gate cleared by command");
        $display("test password done");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_WRITE_REGS, 0, 32'h104);
        rd_reg(`FWP_OFS_CONFIG, 32'h1, "freeze set");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_WRITE_REGS, 0, 32'h8);
        rd_reg(`FWP_OFS_STATUS, 32'h4, "guard frozen");
        run_cmd(FWP_WRITE_ENABLE_CMD);
        run_cmd(FWP_OTP_PROGRAM, 32'h200);
        rd_reg(`FWP_OFS_STATUS, 32'h44, "otp frozen");
        $display("test freeze done");
        summarize();
    end
endmodule
